// file: hdl/ifr_pkg.sv
package ifr_pkg;

  // Bus addressing and frame layout
  localparam logic [7:0] IFR_LOCAL_ADDR = 8'hA0;
  localparam int IFR_I2C_KHZ = 100;
  localparam logic [7:0] IFR_START_CODE = 8'h01;
  localparam logic [15:0] IFR_LEN_START = 16'h0002;
  localparam logic [15:0] IFR_LEN_WRITE = 16'h0102;
  localparam logic [15:0] IFR_LEN_END = 16'h0002;
  localparam logic [7:0] IFR_CMD_START = 8'h02;
  localparam logic [7:0] IFR_CMD_WRITE = 8'h03;
  localparam logic [7:0] IFR_CMD_END = 8'h04;
  localparam logic [8:0] IFR_PAYLOAD_LAST = 9'h0FF;

  // Flash geometry: 1024-byte blocks, 4-byte words
  localparam int IFR_BLOCK_BYTES = 1024;
  localparam int IFR_WORD_BYTES = 4;
  localparam int IFR_ADDR_W = 16;
  localparam int IFR_BLK_LSB = 10;
  localparam int IFR_BLK_W = IFR_ADDR_W - IFR_BLK_LSB;
  localparam logic [IFR_ADDR_W-1:0] IFR_WORD_STEP = 16'h0004;
  localparam logic [IFR_ADDR_W-1:0] IFR_WRITE_BASE = 16'h0000;
  localparam logic [IFR_BLK_W-1:0] IFR_BOOT_LAST_BLK = 6'h03;

  // Error text on the character display, first character in the top byte
  localparam logic [47:0] IFR_ERR_MSG = 48'h4552524F5221;
  localparam logic [2:0] IFR_ERR_MSG_LAST = 3'h5;

  typedef enum logic [2:0] {FOP_INIT, FOP_BLANK, FOP_ERASE, FOP_WRITE, FOP_VERIFY, FOP_BOOTFLIP} ifr_fop_t;

  // Request to the flash self-programming engine, held until done
  typedef struct packed {
    logic req;
    ifr_fop_t op;
    logic [IFR_BLK_W-1:0] blk;
    logic [IFR_ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } ifr_fcmd_t;

  // Answer from the engine: done is a one-cycle pulse, fail and blank valid with it
  typedef struct packed {
    logic done;
    logic fail;
    logic blank;
  } ifr_fsts_t;

  // Shield window limits supplied by the engine
  typedef struct packed {
    logic [IFR_BLK_W-1:0] first_blk;
    logic [IFR_BLK_W-1:0] last_blk;
  } ifr_shield_t;

  typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA} ifr_phase_t;
  typedef enum logic [1:0] {ACK_NONE, ACK_WAIT_LO, ACK_DRIVE, ACK_END} ifr_ack_t;
  typedef enum logic [2:0] {FLD_CODE, FLD_LEN_H, FLD_LEN_L, FLD_CMD, FLD_DATA, FLD_SUM} ifr_fld_t;
  typedef enum logic [3:0] {
    JOB_IDLE, JOB_INIT, JOB_BLANK, JOB_ERASE, JOB_WRITE, JOB_VERIFY, JOB_FLIP, JOB_RESET, JOB_MSG, JOB_HALT
  } ifr_job_t;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic tgl_m;
    logic tgl_s;
    logic tgl_p;
    logic lclr;
    ifr_phase_t ph;
    ifr_ack_t ack;
    logic scl_oe;
    ifr_fld_t fld;
    logic [15:0] len;
    logic [7:0] cmd;
    logic [7:0] sum;
    logic [8:0] cnt;
    logic [31:0] word;
    logic [1:0] wb;
    ifr_job_t job;
    ifr_fop_t fop;
    logic req;
    logic init_ok;
    logic blk_open;
    logic end_seq;
    logic [IFR_ADDR_W-1:0] wptr;
    logic [IFR_BLK_W-1:0] blk;
    logic [2:0] mi;
    logic disp_stb;
    logic [7:0] disp_ch;
    logic rst_pls;
    logic ind1;
    logic ind2;
  } ifr_st_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] data;
    logic tgl;
  } ifr_link_st_t;

endpackage : ifr_pkg

// file: hdl/ifr_link_rx.sv
`timescale 1ns/100ps
// Bit shifter clocked by the bus clock itself; data is sampled on the rising edge as the bus defines
module ifr_link_rx import ifr_pkg::*; (
  // Link clock from the bus, frame clear from the system domain
  input wire logic scl_clk_in,
  input wire logic clear_in,
  // Serial data
  input wire logic sda_in,
  // Received byte, stable for nine bus clocks after each toggle
  output logic [7:0] byte_out,
  output logic byte_tgl_out
);

  ifr_link_st_t s_r;
  ifr_link_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (s_r.cnt == 4'h8) begin
      // Ninth clock carries the acknowledge
      s_nxt.cnt = 4'h0;
    end else begin
      s_nxt.sh = {s_r.sh[6:0], sda_in};
      s_nxt.cnt = s_r.cnt + 4'h1;
      if (s_r.cnt == 4'h7) begin
        s_nxt.data = {s_r.sh[6:0], sda_in};
        s_nxt.tgl = ~s_r.tgl;
      end
    end
  end

  // Clear comes from a system flop raised at START/STOP and dropped while the bus clock is low,
  // so its release never lands near a rising edge of the bus clock.
  // Clearing the toggle keeps it from starting unknown; the receiver ignores the edge this may make
  always_ff @(posedge scl_clk_in or posedge clear_in) begin
    if (clear_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign byte_out = s_r.data;
  assign byte_tgl_out = s_r.tgl;

endmodule : ifr_link_rx

// file: hdl/ifr_cmd_rx.sv
`timescale 1ns/100ps
// Operation
// - Slave at local address 0xA0, standard mode, 100 kHz bus clock.
// - START frame: code 0x01, length 0x0002, command 0x02, no data, checksum.
// - WRITE frame: code 0x01, length 0x0102, command 0x03, 256 data bytes, checksum.
// - END frame: code 0x01, length 0x0002, command 0x04, no data, checksum.
// - Checksum is byte sum of command and data only.
// - START: hold bus in wait, initialise programming, release on success.
// - WRITE: hold bus, program payload, verify each block once complete.
// - END: hold bus, verify current block, invert boot flag, then reset device.
// - Successful command releases the bus, ready for the next frame.
// - Failed command: both indicators on, bus held in wait, halt.
// - Failed command also shows an error message on the character display.
// - Block program or erase outside the shield window.
// - Targets restricted to the boot area; the programmer lives in cluster 0.
// - Erase and verify whole 1024-byte blocks, program 4-byte words.
// - Blank-check the target block, erase only if it holds data.
// - Read-direction addressing turns both indicators on and halts.
module ifr_cmd_rx import ifr_pkg::*; (
  // System clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Bus pins, open drain: clock is also the link clock
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Flash self-programming engine
  output ifr_fcmd_t flash_cmd_out,
  input wire ifr_fsts_t flash_sts_in,
  input wire ifr_shield_t shield_in,
  // Indicators, display and device reset
  output logic first_indicator_out,
  output logic second_indicator_out,
  output logic [7:0] disp_char_out,
  output logic disp_strobe_out,
  output logic dev_reset_out
);

  ifr_st_t s_r;
  ifr_st_t s_nxt;
  logic [7:0] link_byte;
  logic link_tgl;

  ifr_link_rx u_link (
    .scl_clk_in(scl_in),
    .clear_in(s_r.lclr),
    .sda_in(sda_in),
    .byte_out(link_byte),
    .byte_tgl_out(link_tgl)
  );

  logic start_cond;
  logic stop_cond;
  logic byte_ev;
  logic busy;
  logic [IFR_BLK_W-1:0] wblk;
  logic blk_ok;

  assign start_cond = s_r.scl_s && s_r.scl_p && s_r.sda_p && !s_r.sda_s;
  assign stop_cond = s_r.scl_s && s_r.scl_p && !s_r.sda_p && s_r.sda_s;
  assign byte_ev = s_r.tgl_s ^ s_r.tgl_p;
  assign busy = s_r.job != JOB_IDLE;
  assign wblk = s_r.wptr[IFR_ADDR_W-1:IFR_BLK_LSB];
  // Window and boot-area gate applied before any erase or program
  assign blk_ok = (wblk >= shield_in.first_blk) && (wblk <= shield_in.last_blk)
    && (wblk <= IFR_BOOT_LAST_BLK);

  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_m = scl_in;
    s_nxt.scl_s = s_r.scl_m;
    s_nxt.scl_p = s_r.scl_s;
    s_nxt.sda_m = sda_in;
    s_nxt.sda_s = s_r.sda_m;
    s_nxt.sda_p = s_r.sda_s;
    s_nxt.tgl_m = link_tgl;
    s_nxt.tgl_s = s_r.tgl_m;
    s_nxt.tgl_p = s_r.tgl_s;
    s_nxt.disp_stb = 1'b0;
    s_nxt.rst_pls = 1'b0;

    // Link clear rises on START/STOP, falls once the bus clock is low
    if (start_cond || stop_cond) begin
      s_nxt.lclr = 1'b1;
    end else if (!s_r.scl_s) begin
      s_nxt.lclr = 1'b0;
    end

    if (start_cond) begin
      s_nxt.ph = PH_ADDR;
      s_nxt.fld = FLD_CODE;
    end else if (stop_cond) begin
      s_nxt.ph = PH_IDLE;
    end

    // Acknowledge on the ninth clock: drive from the eighth fall to the ninth fall
    unique case (s_r.ack)
      ACK_NONE: begin
      end
      ACK_WAIT_LO: begin
        if (!s_r.scl_s) begin
          s_nxt.ack = ACK_DRIVE;
        end
      end
      ACK_DRIVE: begin
        if (s_r.scl_s) begin
          s_nxt.ack = ACK_END;
        end
      end
      ACK_END: begin
        if (!s_r.scl_s) begin
          s_nxt.ack = ACK_NONE;
        end
      end
    endcase

    // Toggle edges while the link clear stands come from the clear itself, not from a byte
    if (byte_ev && !s_r.lclr && !start_cond && !stop_cond && s_r.job != JOB_HALT && s_r.job != JOB_MSG) begin
      unique case (s_r.ph)
        PH_IDLE: begin
        end
        PH_ADDR: begin
          if (link_byte[7:1] == IFR_LOCAL_ADDR[7:1]) begin
            s_nxt.ack = ACK_WAIT_LO;
            if (link_byte[0]) begin
              s_nxt.job = JOB_HALT;
              s_nxt.ph = PH_IDLE;
            end else begin
              s_nxt.ph = PH_DATA;
            end
          end else begin
            s_nxt.ph = PH_IDLE;
          end
        end
        PH_DATA: begin
          s_nxt.ack = ACK_WAIT_LO;
          unique case (s_r.fld)
            FLD_CODE: begin
              if (link_byte == IFR_START_CODE) begin
                s_nxt.fld = FLD_LEN_H;
              end else begin
                s_nxt.job = JOB_MSG;
              end
            end
            FLD_LEN_H: begin
              s_nxt.len[15:8] = link_byte;
              s_nxt.fld = FLD_LEN_L;
            end
            FLD_LEN_L: begin
              s_nxt.len[7:0] = link_byte;
              s_nxt.fld = FLD_CMD;
            end
            FLD_CMD: begin
              s_nxt.cmd = link_byte;
              s_nxt.sum = link_byte;
              s_nxt.cnt = 9'h000;
              s_nxt.wb = 2'h0;
              if (link_byte == IFR_CMD_WRITE && s_r.len == IFR_LEN_WRITE) begin
                s_nxt.fld = FLD_DATA;
              end else if ((link_byte == IFR_CMD_START && s_r.len == IFR_LEN_START)
                || (link_byte == IFR_CMD_END && s_r.len == IFR_LEN_END)) begin
                s_nxt.fld = FLD_SUM;
              end else begin
                s_nxt.job = JOB_MSG;
              end
            end
            FLD_DATA: begin
              s_nxt.sum = s_r.sum + link_byte;
              s_nxt.word = {link_byte, s_r.word[31:8]};
              s_nxt.wb = s_r.wb + 2'h1;
              s_nxt.cnt = s_r.cnt + 9'h001;
              if (s_r.cnt == IFR_PAYLOAD_LAST) begin
                s_nxt.fld = FLD_SUM;
              end
              // Each complete word is programmed while the bus is stretched
              if (s_r.wb == 2'h3) begin
                if (!s_r.init_ok) begin
                  s_nxt.job = JOB_MSG;
                end else if (s_r.wptr[IFR_BLK_LSB-1:0] != '0) begin
                  s_nxt.job = JOB_WRITE;
                end else if (blk_ok) begin
                  s_nxt.job = JOB_BLANK;
                  s_nxt.blk = wblk;
                end else begin
                  s_nxt.job = JOB_MSG;
                end
              end
            end
            FLD_SUM: begin
              s_nxt.fld = FLD_CODE;
              if (link_byte != s_r.sum) begin
                s_nxt.job = JOB_MSG;
              end else if (s_r.cmd == IFR_CMD_START) begin
                s_nxt.job = JOB_INIT;
              end else if (s_r.cmd == IFR_CMD_END) begin
                s_nxt.end_seq = 1'b1;
                s_nxt.job = (s_r.blk_open && s_r.init_ok) ? JOB_VERIFY : JOB_FLIP;
                if (!s_r.init_ok) begin
                  s_nxt.job = JOB_MSG;
                end
              end
            end
            default: begin
              s_nxt.fld = FLD_CODE;
            end
          endcase
        end
        default: begin
        end
      endcase
    end

    // Flash job sequencing: one request at a time, held until the engine answers
    unique case (s_r.job)
      JOB_INIT, JOB_BLANK, JOB_ERASE, JOB_WRITE, JOB_VERIFY, JOB_FLIP: begin
        s_nxt.req = 1'b1;
        if (s_r.req && flash_sts_in.done) begin
          s_nxt.req = 1'b0;
          if (flash_sts_in.fail) begin
            s_nxt.job = JOB_MSG;
          end else begin
            unique case (s_r.job)
              JOB_INIT: begin
                s_nxt.init_ok = 1'b1;
                s_nxt.wptr = IFR_WRITE_BASE;
                s_nxt.blk_open = 1'b0;
                s_nxt.job = JOB_IDLE;
              end
              JOB_BLANK: begin
                s_nxt.job = flash_sts_in.blank ? JOB_WRITE : JOB_ERASE;
              end
              JOB_ERASE: begin
                s_nxt.job = JOB_WRITE;
              end
              JOB_WRITE: begin
                s_nxt.wptr = s_r.wptr + IFR_WORD_STEP;
                s_nxt.blk_open = 1'b1;
                s_nxt.job = JOB_IDLE;
                if (s_nxt.wptr[IFR_BLK_LSB-1:0] == '0) begin
                  s_nxt.job = JOB_VERIFY;
                end
              end
              JOB_VERIFY: begin
                s_nxt.blk_open = 1'b0;
                s_nxt.job = s_r.end_seq ? JOB_FLIP : JOB_IDLE;
              end
              default: begin
                s_nxt.job = JOB_RESET;
              end
            endcase
          end
        end
      end
      JOB_RESET: begin
        s_nxt.rst_pls = 1'b1;
        s_nxt.init_ok = 1'b0;
        s_nxt.end_seq = 1'b0;
        s_nxt.job = JOB_IDLE;
      end
      JOB_MSG: begin
        s_nxt.disp_stb = 1'b1;
        s_nxt.disp_ch = IFR_ERR_MSG[8 * (5 - s_r.mi) +: 8];
        s_nxt.mi = s_r.mi + 3'h1;
        if (s_r.mi == IFR_ERR_MSG_LAST) begin
          s_nxt.job = JOB_HALT;
        end
      end
      JOB_IDLE, JOB_HALT: begin
        s_nxt.req = 1'b0;
      end
      default: begin
        s_nxt.job = JOB_MSG;
      end
    endcase

    // Mid-command request lines must drop once the job leaves the flash states
    if (s_nxt.job == JOB_MSG || s_nxt.job == JOB_HALT || s_nxt.job == JOB_IDLE || s_nxt.job == JOB_RESET) begin
      s_nxt.req = 1'b0;
    end
    s_nxt.fop = (s_nxt.job == JOB_INIT) ? FOP_INIT :
      (s_nxt.job == JOB_BLANK) ? FOP_BLANK :
      (s_nxt.job == JOB_ERASE) ? FOP_ERASE :
      (s_nxt.job == JOB_VERIFY) ? FOP_VERIFY :
      (s_nxt.job == JOB_FLIP) ? FOP_BOOTFLIP : FOP_WRITE;

    // Stretch only from a low bus clock after the acknowledge, never cutting a high phase
    s_nxt.scl_oe = (busy || s_nxt.job != JOB_IDLE)
      && (s_r.scl_oe || (s_r.ack == ACK_NONE && !s_r.scl_s));

    s_nxt.ind2 = (s_nxt.job != JOB_IDLE && s_nxt.job != JOB_RESET);
    s_nxt.ind1 = (s_nxt.job == JOB_HALT || s_nxt.job == JOB_MSG);
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      s_r <= '0;
      s_r.scl_m <= 1'b1;
      s_r.scl_s <= 1'b1;
      s_r.scl_p <= 1'b1;
      s_r.sda_m <= 1'b1;
      s_r.sda_s <= 1'b1;
      s_r.sda_p <= 1'b1;
      s_r.lclr <= 1'b1;
      s_r.wptr <= IFR_WRITE_BASE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign scl_out = 1'b0;
  assign scl_oe_out = s_r.scl_oe;
  assign sda_out = 1'b0;
  assign sda_oe_out = (s_r.ack == ACK_DRIVE) || (s_r.ack == ACK_END);
  assign flash_cmd_out.req = s_r.req;
  assign flash_cmd_out.op = s_r.fop;
  assign flash_cmd_out.blk = s_r.blk;
  assign flash_cmd_out.addr = s_r.wptr;
  assign flash_cmd_out.wdata = s_r.word;
  assign first_indicator_out = s_r.ind1;
  assign second_indicator_out = s_r.ind2;
  assign disp_char_out = s_r.disp_ch;
  assign disp_strobe_out = s_r.disp_stb;
  assign dev_reset_out = s_r.rst_pls;

endmodule : ifr_cmd_rx

// file: test/ifr_cmd_rx_chk.sv
`timescale 1ns/100ps
module ifr_cmd_rx_chk import ifr_pkg::*; (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Bus drivers
  input wire logic scl_oe_out,
  input wire logic sda_oe_out,
  // Flash engine
  input wire ifr_fcmd_t flash_cmd_out,
  input wire ifr_fsts_t flash_sts_in,
  input wire ifr_shield_t shield_in,
  // Indicators, display, reset
  input wire logic first_indicator_out,
  input wire logic second_indicator_out,
  input wire logic disp_strobe_out,
  input wire logic dev_reset_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  logic flip_seen_r;
  logic flip_seen_nxt;
  logic [7:0] halt_cnt_r;
  logic [7:0] halt_cnt_nxt;
  // Halt must hold the clock once the ninth bit has had time to end
  always_comb begin
    flip_seen_nxt = flip_seen_r | (flash_sts_in.done & ~flash_sts_in.fail & flash_cmd_out.req
      & (flash_cmd_out.op == FOP_BOOTFLIP));
    halt_cnt_nxt = !first_indicator_out ? 8'h00 : halt_cnt_r + {7'h00, halt_cnt_r != 8'hFF};
  end
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      flip_seen_r <= 1'b0;
      halt_cnt_r <= 8'h00;
    end else begin
      flip_seen_r <= flip_seen_nxt;
      halt_cnt_r <= halt_cnt_nxt;
    end
  end
  a_rst_quiet: assert property (
    $rose(resetn_in) |-> !scl_oe_out && !sda_oe_out && !flash_cmd_out.req && !first_indicator_out && !dev_reset_out)
    else $error("outputs active at reset release");
  a_req_steady: assert property (
    flash_cmd_out.req && !flash_sts_in.done |=> flash_cmd_out.req && $stable(flash_cmd_out))
    else $error("flash request changed before done");
  a_req_drop: assert property (
    flash_cmd_out.req && flash_sts_in.done |=> !flash_cmd_out.req)
    else $error("flash request held after done");
  a_halt_sticky: assert property (
    first_indicator_out |=> first_indicator_out && second_indicator_out && !flash_cmd_out.req)
    else $error("halt left or work resumed");
  a_halt_stretch: assert property (
    halt_cnt_r >= 8'h28 |-> scl_oe_out)
    else $error("bus clock released while halted");
  a_msg_burst: assert property (
    $rose(disp_strobe_out) |-> disp_strobe_out [*6] ##1 !disp_strobe_out)
    else $error("display burst not six characters");
  a_msg_halt: assert property (
    $fell(disp_strobe_out) |-> ##[0:8] first_indicator_out)
    else $error("no halt after display burst");
  a_flip_reset: assert property (
    dev_reset_out |-> flip_seen_r ##1 !dev_reset_out)
    else $error("device reset without flip or too long");
  a_shield_window: assert property (
    flash_cmd_out.req && flash_cmd_out.op inside {FOP_ERASE, FOP_WRITE} |-> flash_cmd_out.blk >= shield_in.first_blk
      && flash_cmd_out.blk <= shield_in.last_blk && flash_cmd_out.blk <= IFR_BOOT_LAST_BLK)
    else $error("program or erase outside window");
  a_word_align: assert property (
    flash_cmd_out.req && flash_cmd_out.op == FOP_WRITE |-> flash_cmd_out.addr[1:0] == 2'b00)
    else $error("word write not aligned");
  cover property ($rose(dev_reset_out));
  cover property ($rose(disp_strobe_out));
  cover property (flash_cmd_out.req && flash_cmd_out.op == FOP_ERASE);
endmodule : ifr_cmd_rx_chk
bind ifr_cmd_rx ifr_cmd_rx_chk u_chk (
  .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .scl_oe_out(scl_oe_out), .sda_oe_out(sda_oe_out),
  .flash_cmd_out(flash_cmd_out), .flash_sts_in(flash_sts_in), .shield_in(shield_in),
  .first_indicator_out(first_indicator_out), .second_indicator_out(second_indicator_out),
  .disp_strobe_out(disp_strobe_out), .dev_reset_out(dev_reset_out));

// file: test/ifr_master.sv
`timescale 1ns/100ps
module ifr_master (
  // Wire levels
  input wire logic scl_in,
  input wire logic sda_in,
  // Pull-downs onto the wires
  output logic scl_low_out,
  output logic sda_low_out
);
  // Bit time unrelated to the system clock
  localparam int HALF_NS = 403;
  logic stuck = 1'b0;
  initial {scl_low_out, sda_low_out} = 2'b00;
  // Bounded wait: a halted slave holds the clock low for good
  task automatic release_scl();
    int n;
    n = 0;
    scl_low_out = 1'b0;
    while (scl_in !== 1'b1 && n < 2000) begin
      #50;
      n++;
    end
    stuck = scl_in !== 1'b1;
    #(HALF_NS / 2);
  endtask : release_scl
  task automatic clock_bit(input logic b, output logic r);
    r = 1'b1;
    if (!stuck) begin
      sda_low_out = !b;
      #(HALF_NS);
      release_scl();
      r = sda_in;
      #(HALF_NS / 2);
      scl_low_out = 1'b1;
    end
  endtask : clock_bit
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], r);
    end
    clock_bit(1'b1, r);
    ack = !r;
  endtask : send_byte
  task automatic start_cond();
    stuck = 1'b0;
    #(HALF_NS);
    sda_low_out = 1'b1;
    #(HALF_NS);
    scl_low_out = 1'b1;
  endtask : start_cond
  task automatic stop_cond();
    sda_low_out = 1'b1;
    #(HALF_NS);
    release_scl();
    sda_low_out = 1'b0;
    #(HALF_NS);
  endtask : stop_cond
endmodule : ifr_master

// file: test/ifr_cmd_rx_bench.sv
`timescale 1ns/100ps
module ifr_cmd_rx_bench;
  import ifr_pkg::*;
  typedef struct packed {logic [7:0] code; logic [15:0] len; logic [7:0] cmd; logic [7:0] sumx;
    logic pre; logic fail; logic halt;} ifr_row_t;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic scl_oe, sda_oe, m_scl_low, m_sda_low, ind1, ind2, dstb, drst, ack;
  logic fail_on = 1'b0;
  logic blank_on = 1'b0;
  logic [7:0] dchar;
  logic [47:0] msg = '0;
  ifr_fcmd_t fcmd;
  ifr_fsts_t fsts = '0;
  ifr_shield_t shield = {6'h00, 6'h0F};
  ifr_fcmd_t log_q[$];
  int lat = 0;
  int wait_n = 0;
  int msg_n = 0;
  int n_rst = 0;
  int n_mismatch = 0;
  int check_count = 0;
  // Pull-ups on both wires
  wire logic scl_w = !(m_scl_low || scl_oe);
  wire logic sda_w = !(m_sda_low || sda_oe);
  ifr_row_t rows [8] = '{
    '{8'h01, 16'h0002, 8'h02, 8'h00, 1'b0, 1'b0, 1'b0},
    '{8'h02, 16'h0002, 8'h02, 8'h00, 1'b0, 1'b0, 1'b1},
    '{8'h01, 16'h0003, 8'h02, 8'h00, 1'b0, 1'b0, 1'b1},
    '{8'h01, 16'h0002, 8'h05, 8'h00, 1'b0, 1'b0, 1'b1},
    '{8'h01, 16'h0002, 8'h02, 8'h01, 1'b0, 1'b0, 1'b1},
    '{8'h01, 16'h0002, 8'h04, 8'h00, 1'b0, 1'b0, 1'b1},
    '{8'h01, 16'h0002, 8'h02, 8'h00, 1'b0, 1'b1, 1'b1},
    '{8'h01, 16'h0002, 8'h04, 8'h00, 1'b1, 1'b0, 1'b0}};
  always #25 sys_clk = !sys_clk;
  ifr_cmd_rx dut (
    .sys_clk_in(sys_clk), .resetn_in(resetn), .scl_in(scl_w), .scl_out(), .scl_oe_out(scl_oe),
    .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe), .flash_cmd_out(fcmd), .flash_sts_in(fsts),
    .shield_in(shield), .first_indicator_out(ind1), .second_indicator_out(ind2),
    .disp_char_out(dchar), .disp_strobe_out(dstb), .dev_reset_out(drst));
  ifr_master u_master (.scl_in(scl_w), .sda_in(sda_w), .scl_low_out(m_scl_low), .sda_low_out(m_sda_low));
  // Engine model: fail and blank wander outside the done pulse
  always @(posedge sys_clk) begin
    if (fcmd.req === 1'b1 && fsts.done !== 1'b1 && wait_n >= lat) begin
      log_q.push_back(fcmd);
      wait_n <= 0;
      fsts <= #1 {1'b1, fail_on, blank_on};
    end else begin
      wait_n <= (fcmd.req === 1'b1 && fsts.done !== 1'b1) ? wait_n + 1 : 0;
      fsts <= #1 {1'b0, wait_n[0], !wait_n[0]};
    end
    if (dstb === 1'b1) begin
      msg <= {msg[39:0], dchar};
      msg_n <= msg_n + 1;
    end
    n_rst <= n_rst + int'(drst === 1'b1);
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic do_reset(input logic [5:0] first_blk);
    @(posedge sys_clk);
    #1;
    resetn = 1'b0;
    shield.first_blk = first_blk;
    log_q = {};
    msg_n = 0;
    n_rst = 0;
    repeat (10) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    repeat (10) @(posedge sys_clk);
  endtask : do_reset
  function automatic logic [7:0] pay(input int i);
    return 8'(i * 7 + 3);
  endfunction : pay
  task automatic send_frame(input logic [7:0] code, input logic [15:0] len, input logic [7:0] cmd,
    input logic [7:0] sumx, input int npay);
    logic [7:0] sum;
    sum = cmd;
    u_master.start_cond();
    u_master.send_byte(IFR_LOCAL_ADDR, ack);
    check(ack, 1'b1);
    u_master.send_byte(code, ack);
    u_master.send_byte(len[15:8], ack);
    u_master.send_byte(len[7:0], ack);
    u_master.send_byte(cmd, ack);
    for (int i = 0; i < npay; i++) begin
      u_master.send_byte(pay(i), ack);
      sum = sum + pay(i);
    end
    u_master.send_byte(sum ^ sumx, ack);
    u_master.stop_cond();
    repeat (20) @(posedge sys_clk);
  endtask : send_frame
  task automatic conclude();
    $display("mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  initial begin : main
    foreach (rows[k]) begin
      do_reset(6'h00);
      lat = 20;
      fail_on = rows[k].fail;
      if (rows[k].pre) send_frame(8'h01, 16'h0002, 8'h02, 8'h00, 0);
      send_frame(rows[k].code, rows[k].len, rows[k].cmd, rows[k].sumx, 0);
      check({ind1, ind2, scl_oe}, {3{rows[k].halt}});
      check(msg_n, rows[k].halt ? 6 : 0);
      check(n_rst, rows[k].pre);
      if (rows[k].halt) check(msg, "ERROR!");
      else check(log_q[0].op, FOP_INIT);
    end
    fail_on = 1'b0;
    lat = 0;
    do_reset(6'h00);
    u_master.start_cond();
    u_master.send_byte(8'hA2, ack);
    check(ack, 1'b0);
    u_master.stop_cond();
    u_master.start_cond();
    u_master.send_byte(8'hA1, ack);
    u_master.stop_cond();
    repeat (20) @(posedge sys_clk);
    check({ind1, ind2, msg_n[2:0]}, 5'b11000);
    do_reset(6'h00);
    send_frame(8'h01, 16'h0002, 8'h02, 8'h00, 0);
    send_frame(8'h01, 16'h0102, 8'h03, 8'h00, 256);
    send_frame(8'h01, 16'h0002, 8'h04, 8'h00, 0);
    check(log_q.size(), 69);
    check({log_q[1].op, log_q[2].op, log_q[67].op, log_q[68].op},
      {FOP_BLANK, FOP_ERASE, FOP_VERIFY, FOP_BOOTFLIP});
    for (int w = 0; w < 64; w++) begin
      check({log_q[w + 3].op, log_q[w + 3].addr, log_q[w + 3].wdata},
        {FOP_WRITE, 16'(w * 4), pay(4 * w + 3), pay(4 * w + 2), pay(4 * w + 1), pay(4 * w)});
    end
    check({n_rst, ind1}, {32'd1, 1'b0});
    do_reset(6'h01);
    send_frame(8'h01, 16'h0002, 8'h02, 8'h00, 0);
    send_frame(8'h01, 16'h0102, 8'h03, 8'h00, 256);
    check({ind1, msg_n[2:0]}, 4'b1110);
    check(log_q[log_q.size() - 1].op inside {FOP_INIT, FOP_BLANK}, 1'b1);
    do_reset(6'h00);
    blank_on = 1'b1;
    send_frame(8'h01, 16'h0002, 8'h02, 8'h00, 0);
    send_frame(8'h01, 16'h0102, 8'h03, 8'h00, 4);
    check({log_q.size(), log_q[2].op, ind1}, {32'd3, FOP_WRITE, 1'b0});
    conclude();
  end
  initial begin : watchdog
    repeat (95000) @(posedge sys_clk);
    n_mismatch++;
    conclude();
  end
endmodule : ifr_cmd_rx_bench
